// ==== smls_adc_model.sv ====
// Purpose: ADC stand-in that finishes a conversion after each trigger
// Assumes: Shares the sequencer clock
// Notes:   A new trigger restarts a conversion still in flight
`timescale 1ns/100ps
`default_nettype none
module smls_adc_model
#(
	parameter LAT = 1
)
(
	input  wire clk_in,
	input  wire rstn_in,
	input  wire trig_in,
	output reg  done_out
);
localparam [7:0] LAT8 = LAT;
reg [7:0] cnt_r;
always @(posedge clk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		cnt_r    <= 8'h00;
		done_out <= 1'b0;
	end
	else
	begin
		done_out <= 1'b0;
		if (trig_in)
			cnt_r <= LAT8;
		else if (cnt_r != 8'h00)
		begin
			cnt_r    <= cnt_r - 8'h01;
			done_out <= cnt_r == 8'h01;
		end
	end
end
endmodule
`default_nettype wire

// ==== smls_defs.vh ====
// Purpose: Constants for the low-power direct measurement sequencer
// Assumes: 8-bit register port, one 125 MHz clock
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef SMLS_DEFS_VH
`define SMLS_DEFS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SMLS_ADDR_W        8
`define SMLS_DATA_W        8
`define SMLS_STATCTL_ADDR  8'h40
`define SMLS_CTRL_ADDR     8'h41
`define SMLS_ISD_ADDR      8'h42
`define SMLS_SP_ADDR       8'h43

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SMLS_SC_FLAG       7
`define SMLS_SC_ACK        6
`define SMLS_SC_IE         5
`define SMLS_SC_SEN        4
`define SMLS_SC_LOW_POWER_DIRECT_MODE       3
`define SMLS_CT_EN         7
`define SMLS_CT_CAP        6

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SMLS_STATCTL_RST   8'h00
`define SMLS_CTRL_RST      8'h00
`define SMLS_ISD_RST       8'h10
`define SMLS_SP_RST        8'h04

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SMLS_CLK_PERIOD_NS 8
`define SMLS_TICK_NS       1000
`define SMLS_TICK_CYCLES   ((`SMLS_TICK_NS + `SMLS_CLK_PERIOD_NS - 1) / `SMLS_CLK_PERIOD_NS)
`define SMLS_PRE_W         16

`endif

// ==== smls_props.sv ====
// Purpose: Port assertions for the measurement sequencer
// Assumes: Read data answer one cycle after the read strobe
// Notes:   Bound to every smls_seq instance
`timescale 1ns/100ps
`default_nettype none
`include "smls_defs.vh"
module smls_props
(
	// Clock and reset
	input wire       clk_in,
	input wire       rstn_in,
	// Register port
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire       reg_wr_in,
	input wire       reg_rd_in,
	input wire [7:0] reg_rdata_out,
	// Processor and ADC side
	input wire       cpu_running_in,
	input wire       adc_done_in,
	input wire       adc_result_read_in,
	input wire       adc_trigger_out,
	input wire       conversion_complete_out,
	input wire       measure_irq_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!rstn_in);
wire rd_sc  = reg_rd_in && reg_addr_in == `SMLS_STATCTL_ADDR;
wire rd_unm = reg_rd_in && (reg_addr_in < `SMLS_STATCTL_ADDR
	|| reg_addr_in > `SMLS_SP_ADDR);
wire ack_wr = reg_wr_in && reg_addr_in == `SMLS_STATCTL_ADDR
	&& reg_wdata_in[`SMLS_SC_ACK];
wire cap_wr = reg_wr_in && reg_addr_in == `SMLS_CTRL_ADDR
	&& reg_wdata_in == 8'hC0;
chk_rd_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
	else $error("read data not zero outside read slot");
chk_rsvd_zero: assert property ($past(rd_sc) |-> (reg_rdata_out & 8'h47) == 8'h00)
	else $error("reserved or ack bit read nonzero");
chk_unmapped: assert property ($past(rd_unm) |-> reg_rdata_out == 8'h00)
	else $error("unmapped read nonzero");
chk_flag_read: assert property ($past(rd_sc) |-> reg_rdata_out[7] == $past(measure_irq_out))
	else $error("flag bit differs from irq output");
chk_cc_set: assert property (adc_done_in |=> conversion_complete_out)
	else $error("complete not set after done");
chk_cc_clear: assert property ($fell(conversion_complete_out) |-> $past(adc_result_read_in))
	else $error("complete dropped without result read");
chk_cc_cause: assert property ($rose(conversion_complete_out) |-> $past(adc_done_in))
	else $error("complete rose without done");
chk_ack_only: assert property ($fell(measure_irq_out) |-> $past(ack_wr))
	else $error("flag cleared without ack");
chk_irq_stop: assert property ($rose(measure_irq_out) |-> $past(cpu_running_in))
	else $error("flag set while processor stopped");
chk_cap_sync: assert property (cap_wr |=> !adc_trigger_out [*3])
	else $error("trigger too soon after capture");
chk_trig_pulse: assert property (adc_trigger_out |=> !adc_trigger_out)
	else $error("trigger longer than one cycle");
cover property (cap_wr ##[1:200] adc_trigger_out);
cover property ($rose(measure_irq_out));
cover property ($fell(conversion_complete_out));
endmodule
bind smls_seq smls_props u_props (.clk_in(clk_in), .rstn_in(rstn_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .cpu_running_in(cpu_running_in),
	.adc_done_in(adc_done_in), .adc_result_read_in(adc_result_read_in),
	.adc_trigger_out(adc_trigger_out),
	.conversion_complete_out(conversion_complete_out),
	.measure_irq_out(measure_irq_out));
`default_nettype wire

// ==== smls_seq.v ====
// Purpose: Low-power direct measurement sequencer with its status and
//          control registers, settle timing and ADC trigger
// Assumes: ADC and processor power status share clk_in; register port
//          reads answer one cycle after the read strobe
// Notes:   Settle intervals count in ticks of one microsecond
`timescale 1ns/100ps
`default_nettype none

`include "smls_defs.vh"

// Notes on behaviour
// RL1: Firmware enters with writes: mode bit, then enable, then capture.
// RL2: Capture set is synchronised; first trigger after the initial delay.
// RL3: Later settle periods start at each trigger; repeats until exit.
// RL4: Every new entry uses the initial delay first, then repeat period.
// RL5: Capture bit stays set in the mode; clears when mode bit drops.
// RL6: Firmware exits by clearing enable then mode bit, two writes.
// RL7: Firmware changes intervals only right after the ADC wake-up.
// RL8: Conversion complete sets on ADC finish, clears on result read.
// RL9: Hardware alone times acquisition, so processor may stay stopped.
// RL10: Firmware should rerun the initial delay after changing settings.
// RL11: Flag bit 7 sets at settle end if running, enabled, mode off.
// RL12: Writing one to ack bit 6 clears the flag; zero does nothing.
// RL13: Ack bit always reads zero and holds no reset state.
// RL14: Interrupt disabled in stop state or while low-power mode is on.
// RL15: Interrupt enable bit 5 has no effect while auto acquire is clear.
// RL16: Status register at 0x40 resets to zero; bit 6 and 2..0 read zero.
// RL17: Auto acquire bit reads one while a measurement is underway.
// RL18: Capture writes are ignored while auto acquisition is active.
module smls_seq
#(
	parameter TICK_CYCLES = `SMLS_TICK_CYCLES
)
(
	// Clock and reset
	input  wire                    clk_in,
	input  wire                    rstn_in,
	// Register port
	input  wire [`SMLS_ADDR_W-1:0] reg_addr_in,
	input  wire [`SMLS_DATA_W-1:0] reg_wdata_in,
	input  wire                    reg_wr_in,
	input  wire                    reg_rd_in,
	output reg  [`SMLS_DATA_W-1:0] reg_rdata_out,
	// Processor and ADC status
	input  wire                    cpu_running_in,
	input  wire                    adc_done_in,
	input  wire                    adc_result_read_in,
	// Outputs to ADC and interrupt controller
	output reg                     adc_trigger_out,
	output reg                     conversion_complete_out,
	output reg                     measure_irq_out
);

	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_SYNC = 5'h02;
	localparam [4:0] ST_ISD  = 5'h04;
	localparam [4:0] ST_SP   = 5'h08;
	localparam [4:0] ST_WAIT = 5'h10;

	localparam [`SMLS_PRE_W-1:0] PRE_LAST = TICK_CYCLES - 1;

	// ---------------------------------------------------------------
	// Decode helper
	// ---------------------------------------------------------------
	function hit;
		input [`SMLS_ADDR_W-1:0] a;
		input [`SMLS_ADDR_W-1:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	reg                     flag_r;
	reg                     flag_nxt;
	reg                     ie_r;
	reg                     ie_nxt;
	reg                     sen_r;
	reg                     sen_nxt;
	reg                     low_power_direct_mode_r;
	reg                     low_power_direct_mode_nxt;
	reg                     en_r;
	reg                     en_nxt;
	reg                     cap_r;
	reg                     cap_nxt;
	reg [7:0]               isd_r;
	reg [7:0]               isd_nxt;
	reg [7:0]               sp_r;
	reg [7:0]               sp_nxt;
	reg [4:0]               state_r;
	reg [4:0]               state_nxt;
	reg [7:0]               cnt_r;
	reg [7:0]               cnt_nxt;
	reg [`SMLS_PRE_W-1:0]   pre_r;
	reg [`SMLS_PRE_W-1:0]   pre_nxt;
	reg                     trig_nxt;
	reg                     cc_nxt;
	reg [`SMLS_DATA_W-1:0]  rdata_nxt;

	wire wr_sc  = reg_wr_in & hit(reg_addr_in, `SMLS_STATCTL_ADDR);
	wire wr_ct  = reg_wr_in & hit(reg_addr_in, `SMLS_CTRL_ADDR);
	wire wr_isd = reg_wr_in & hit(reg_addr_in, `SMLS_ISD_ADDR);
	wire wr_sp  = reg_wr_in & hit(reg_addr_in, `SMLS_SP_ADDR);

	wire run_low_power_direct_mode = low_power_direct_mode_r & en_r & cap_r;
	wire tick     = (pre_r == PRE_LAST);
	// A zero interval still lasts one tick
	wire per_end  = tick & (cnt_r <= 8'h01);
	wire timing   = state_r[2] | state_r[3];

	// ---------------------------------------------------------------
	// Software-visible bits
	// ---------------------------------------------------------------
	always @*
	begin
		low_power_direct_mode_nxt = low_power_direct_mode_r;
		ie_nxt   = ie_r;
		en_nxt   = en_r;
		isd_nxt  = isd_r;
		sp_nxt   = sp_r;
		if (wr_sc)
		begin
			low_power_direct_mode_nxt = reg_wdata_in[`SMLS_SC_LOW_POWER_DIRECT_MODE];
			ie_nxt   = reg_wdata_in[`SMLS_SC_IE];
		end
		// Enable cannot be raised while an auto measurement runs
		if (wr_ct)
			en_nxt = reg_wdata_in[`SMLS_CT_EN] & ~sen_r;
		// New intervals take effect at the next period load
		if (wr_isd)
			isd_nxt = reg_wdata_in;
		if (wr_sp)
			sp_nxt = reg_wdata_in;
	end

	// Auto acquire starts only from idle and clears on ADC finish
	always @*
	begin
		sen_nxt = sen_r;
		if (wr_sc & reg_wdata_in[`SMLS_SC_SEN] & ~sen_r & ~en_r & ~low_power_direct_mode_r)
			sen_nxt = 1'b1; // RL17
		else if (state_r[4] & adc_done_in)
			sen_nxt = 1'b0; // RL17
	end

	// Capture is held for the whole low-power session
	always @*
	begin
		cap_nxt = cap_r;
		if (~low_power_direct_mode_r)
			cap_nxt = 1'b0; // RL5
		else if (wr_ct & reg_wdata_in[`SMLS_CT_CAP] & ~sen_r & en_r)
			cap_nxt = 1'b1; // RL18
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always @*
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		pre_nxt   = timing ? (tick ? {`SMLS_PRE_W{1'b0}} : pre_r + 1'b1)
		                   : {`SMLS_PRE_W{1'b0}};
		trig_nxt  = 1'b0;
		if (timing & tick & ~per_end)
			cnt_nxt = cnt_r - 8'h01;
		case (state_r)
			ST_IDLE:
			begin
				if (run_low_power_direct_mode)
					state_nxt = ST_SYNC; // RL2
				else if (sen_r)
				begin
					state_nxt = ST_ISD;
					cnt_nxt   = isd_r;
				end
			end
			ST_SYNC:
			begin
				// Each fresh entry runs the initial delay first
				state_nxt = ST_ISD; // RL4
				cnt_nxt   = isd_r;
				pre_nxt   = {`SMLS_PRE_W{1'b0}};
			end
			ST_ISD:
			begin
				if (~sen_r & ~run_low_power_direct_mode)
					state_nxt = ST_IDLE; // RL3
				else if (per_end)
				begin
					trig_nxt = 1'b1; // RL2
					if (sen_r)
						state_nxt = ST_WAIT;
					else
					begin
						state_nxt = ST_SP; // RL4
						cnt_nxt   = sp_r; // RL3
					end
				end
			end
			ST_SP:
			begin
				// No software action needed between triggers
				if (~run_low_power_direct_mode)
					state_nxt = ST_IDLE; // RL3
				else if (per_end)
				begin
					trig_nxt = 1'b1; // RL9
					cnt_nxt  = sp_r; // RL3
				end
			end
			ST_WAIT:
			begin
				if (adc_done_in)
					state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Flag, completion and read data
	// ---------------------------------------------------------------
	always @*
	begin
		// Set beats a same-cycle acknowledge
		flag_nxt = flag_r & ~(wr_sc & reg_wdata_in[`SMLS_SC_ACK]); // RL12
		if (timing & per_end & cpu_running_in & ie_r & ~low_power_direct_mode_r & sen_r)
			flag_nxt = 1'b1; // RL11 RL14 RL15
		cc_nxt = conversion_complete_out & ~adc_result_read_in; // RL8
		if (adc_done_in)
			cc_nxt = 1'b1; // RL8
	end

	always @*
	begin
		rdata_nxt = 8'h00;
		if (reg_rd_in)
		begin
			if (hit(reg_addr_in, `SMLS_STATCTL_ADDR))
			begin
				// Ack and low bits always read back as zero
				rdata_nxt[`SMLS_SC_FLAG] = flag_r; // RL16 RL13
				rdata_nxt[`SMLS_SC_IE]   = ie_r;
				rdata_nxt[`SMLS_SC_SEN]  = sen_r; // RL17
				rdata_nxt[`SMLS_SC_LOW_POWER_DIRECT_MODE] = low_power_direct_mode_r;
			end
			else if (hit(reg_addr_in, `SMLS_CTRL_ADDR))
			begin
				rdata_nxt[`SMLS_CT_EN]  = en_r;
				rdata_nxt[`SMLS_CT_CAP] = cap_r;
			end
			else if (hit(reg_addr_in, `SMLS_ISD_ADDR))
				rdata_nxt = isd_r;
			else if (hit(reg_addr_in, `SMLS_SP_ADDR))
				rdata_nxt = sp_r;
		end
	end

	// ---------------------------------------------------------------
	// Flip-flops
	// ---------------------------------------------------------------
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			flag_r                  <= 1'b0; // RL16
			ie_r                    <= 1'b0;
			sen_r                   <= 1'b0;
			low_power_direct_mode_r                  <= 1'b0;
			en_r                    <= 1'b0;
			cap_r                   <= 1'b0;
			isd_r                   <= `SMLS_ISD_RST;
			sp_r                    <= `SMLS_SP_RST;
			state_r                 <= ST_IDLE;
			cnt_r                   <= 8'h00;
			pre_r                   <= {`SMLS_PRE_W{1'b0}};
			adc_trigger_out         <= 1'b0;
			conversion_complete_out <= 1'b0;
			measure_irq_out         <= 1'b0;
			reg_rdata_out           <= 8'h00;
		end
		else
		begin
			flag_r                  <= flag_nxt;
			ie_r                    <= ie_nxt;
			sen_r                   <= sen_nxt;
			low_power_direct_mode_r                  <= low_power_direct_mode_nxt;
			en_r                    <= en_nxt;
			cap_r                   <= cap_nxt;
			isd_r                   <= isd_nxt;
			sp_r                    <= sp_nxt;
			state_r                 <= state_nxt;
			cnt_r                   <= cnt_nxt;
			pre_r                   <= pre_nxt;
			adc_trigger_out         <= trig_nxt;
			conversion_complete_out <= cc_nxt;
			measure_irq_out         <= flag_nxt;
			reg_rdata_out           <= rdata_nxt;
		end
	end

endmodule

`default_nettype wire

// ==== smls_seq_tb.sv ====
// Purpose: Register-level test of the measurement sequencer
// Assumes: Tick shortened to 2 cycles
// Notes:   Processor held stopped during the low-power runs
`timescale 1ns/100ps
`default_nettype none
module smls_seq_tb;
reg        clk_in, rstn_in, wr, rd, cpu, rres;
reg  [7:0] addr, wdata;
wire [7:0] rdata;
wire       trig, done, cc, irq;
integer    fails, n_compared, cyc, n, i;
reg  [7:0] mode_v [0:2] = '{8'h30, 8'h30, 8'h10};
reg  [2:0] cpu_v = 3'b101;
reg  [2:0] exp_v = 3'b001;
smls_seq #(.TICK_CYCLES(2)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
	.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
	.reg_rd_in(rd), .reg_rdata_out(rdata), .cpu_running_in(cpu),
	.adc_done_in(done), .adc_result_read_in(rres),
	.adc_trigger_out(trig), .conversion_complete_out(cc),
	.measure_irq_out(irq));
smls_adc_model #(.LAT(1)) adc (.clk_in(clk_in), .rstn_in(rstn_in),
	.trig_in(trig), .done_out(done));
// ---------------------------------------------------------------
// Access tasks
// ---------------------------------------------------------------
task chk(input [7:0] got, input [7:0] exp);
begin
	n_compared = n_compared + 1;
	if (got !== exp)
	begin
		fails = fails + 1;
		$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
	end
end
endtask
task wr_reg(input [7:0] a, input [7:0] d);
begin
	@(posedge clk_in);
	addr <= a; wdata <= d; wr <= 1'b1;
	@(posedge clk_in);
	wr <= 1'b0;
end
endtask
task rd_reg(input [7:0] a, input [7:0] exp);
begin
	@(posedge clk_in);
	addr <= a; rd <= 1'b1;
	@(posedge clk_in);
	rd <= 1'b0;
	#1 chk(rdata, exp);
end
endtask
// Edges until the trigger is seen, bounded so a dead sequencer fails
task gap;
begin
	n = 0;
	do
	begin
		@(posedge clk_in);
		#1 n = n + 1;
	end while (trig !== 1'b1 && n < 200);
end
endtask
task enter;
begin
	wr_reg(8'h40, 8'h08);
	wr_reg(8'h41, 8'h80);
	wr_reg(8'h41, 8'hC0);
	gap; chk(n[7:0], 8'h06);
end
endtask
task conclude;
begin
	$display("compared %0d mismatches %0d", n_compared, fails);
	if (fails == 0 && n_compared > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
end
endtask
initial
begin
	clk_in = 0;
	forever #4 clk_in = ~clk_in;
end
always @(posedge clk_in)
begin
	cyc <= cyc + 1;
	if (cyc == 5000)
	begin
		fails = fails + 1;
		conclude;
	end
end
// ---------------------------------------------------------------
// Scenarios
// ---------------------------------------------------------------
initial
begin
	rstn_in = 0; wr = 0; rd = 0; cpu = 0; rres = 0;
	addr = 8'h00; wdata = 8'h00; fails = 0; n_compared = 0; cyc = 0;
	repeat (6) @(posedge clk_in);
	rstn_in <= 1'b1;
	rd_reg(8'h40, 8'h00); rd_reg(8'h41, 8'h00);
	rd_reg(8'h42, 8'h10); rd_reg(8'h43, 8'h04);
	rd_reg(8'h50, 8'h00);
	wr_reg(8'h40, 8'h48); rd_reg(8'h40, 8'h08);
	wr_reg(8'h41, 8'hC0); rd_reg(8'h41, 8'h80);
	wr_reg(8'h41, 8'h00);
	wr_reg(8'h42, 8'h02); wr_reg(8'h43, 8'h01);
	enter;
	repeat (3)
	begin
		gap; chk(n[7:0], 8'h02);
	end
	rd_reg(8'h41, 8'hC0);
	wr_reg(8'h41, 8'h00); wr_reg(8'h40, 8'h00);
	rd_reg(8'h41, 8'h00);
	n = 0;
	repeat (20)
	begin
		@(posedge clk_in);
		#1 n = n + trig;
	end
	chk(n[7:0], 8'h00);
	chk({7'h00, cc}, 8'h01);
	@(posedge clk_in) rres <= 1'b1;
	@(posedge clk_in) rres <= 1'b0;
	#1 chk({7'h00, cc}, 8'h00);
	enter;
	wr_reg(8'h41, 8'h00); wr_reg(8'h40, 8'h00);
	for (i = 0; i < 3; i = i + 1)
	begin
		cpu <= cpu_v[i];
		wr_reg(8'h40, mode_v[i]);
		gap;
		@(posedge clk_in);
		#1 chk({7'h00, irq}, {7'h00, exp_v[i]});
		wr_reg(8'h40, mode_v[i] & 8'h20);
		rd_reg(8'h40, {exp_v[i], 7'h00} | (mode_v[i] & 8'h20));
		wr_reg(8'h40, 8'h40);
		#1 chk({7'h00, irq}, 8'h00);
	end
	conclude;
end
endmodule
`default_nettype wire

// ==== smls_wrap_unused.v ====
`timescale 1ns/100ps
`default_nettype none
// Purpose: none
`default_nettype wire
